// ===== system_clock_tree_control.sv
// System clock tree control with AXI4-Lite register access
// Summary of operation
// RULE1: Fast internal clock is RC oscillator divided by 1,2,4,6,...,16.
// RULE2: Root clock picks one of four sources by select field.
// RULE3: Core bus clock is root clock divided by 2^n, n 0 to 7.
// RULE4: Peripheral bus clock is core clock divided by 2^n, n 0 to 3.
// RULE5: Sleep halts processor only; oscillators and peripherals keep running.
// RULE6: Deep-sleep halts processor and turns off both fast oscillators.
// RULE7: Deep-sleep leaves slow and RC oscillators as they were.
// RULE8: In deep-sleep bus clocks run only while selected source runs.
// RULE9: Wake select 1 forces fast internal clock as source on wake.
// RULE10: Wake select 0 holds processor until previous source is stable.
// RULE11: Software should pick fast internal clock or wake select first.
// RULE12: External mode 0 is resonator, 1 is digital clock input.
// RULE13: Clock input mode frees the second oscillator pin for general use.
// RULE14: Software sets crystal range code to match crystal frequency.
// RULE15: Fast external oscillator has four drive strength levels.
// RULE16: 10 kHz clock goes to watchdog and I/O interrupt filters.
// RULE17: 150 kHz clock goes to detector, comparator and I/O filters.
// RULE18: Dedicated 32MHz oscillator clocks the radio only.
// RULE19: Fast internal divider defaults to six after reset.
// RULE20: Fast internal RC oscillator runs at 48MHz before division.
// RULE21: Fast external stable after 8192/32768/131072/262144 counted cycles.
// RULE22: Source and prescaler changes never cut clock pulses short.
// RULE23: Never switch to a source that is not yet stable.
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module system_clock_tree_control
	import clock_tree_pkg::*;
#(
	parameter int FE_COUNT0 = FE_WAIT0,
	parameter int FE_COUNT1 = FE_WAIT1,
	parameter int FE_COUNT2 = FE_WAIT2,
	parameter int FE_COUNT3 = FE_WAIT3
) (
	input  wire logic                                 clk_in,
	input  wire logic                                 rst_in,
	input  wire logic [clock_tree_pkg::AXI_AW-1:0]    axi_awaddr_in,
	input  wire logic                                 axi_awvalid_in,
	output logic                                      axi_awready_out,
	input  wire logic [clock_tree_pkg::AXI_DW-1:0]    axi_wdata_in,
	input  wire logic [clock_tree_pkg::AXI_DW/8-1:0]  axi_wstrb_in,
	input  wire logic                                 axi_wvalid_in,
	output logic                                      axi_wready_out,
	output logic [1:0]                                axi_bresp_out,
	output logic                                      axi_bvalid_out,
	input  wire logic                                 axi_bready_in,
	input  wire logic [clock_tree_pkg::AXI_AW-1:0]    axi_araddr_in,
	input  wire logic                                 axi_arvalid_in,
	output logic                                      axi_arready_out,
	output logic [clock_tree_pkg::AXI_DW-1:0]         axi_rdata_out,
	output logic [1:0]                                axi_rresp_out,
	output logic                                      axi_rvalid_out,
	input  wire logic                                 axi_rready_in,
	input  wire logic                                 sleep_req_in,
	input  wire logic                                 deep_sleep_in,
	input  wire logic                                 wake_req_in,
	input  wire logic [clock_tree_pkg::OSC_NUM-1:0]   fast_pin_a,
	output logic                                      cpu_halt_out,
	output logic                                      root_tick_out,
	output logic                                      core_bus_tick_out,
	output logic                                      periph_bus_tick_out,
	output logic [clock_tree_pkg::EN_NUM-1:0]         osc_enable_out,
	output logic                                      fast_pin_a_digital_out,
	output logic                                      fast_pin_b_gpio_out,
	output logic [1:0]                                crystal_range_out,
	output logic [1:0]                                drive_strength_out,
	output logic                                      rc_10khz_tick_out,
	output logic                                      rc_150khz_tick_out,
	output logic                                      radio_tick_out
);
	import clock_tree_pkg::*;

	logic [OSC_NUM-1:0] rise;
	logic               fi_tick;
	logic               core_tick;
	logic [1:0]  src_sel_q, src_sel_d, act_q, act_d;
	logic [2:0]  core_pre_q, core_pre_d;
	logic [1:0]  per_pre_q, per_pre_d;
	logic [EN_NUM-1:0] osc_on_q, osc_on_d, en_q, en_d;
	logic        wake_sel_q, wake_sel_d;
	logic [3:0]  fi_div_q, fi_div_d;
	logic        fe_mode_q, fe_mode_d;
	logic [1:0]  fe_range_q, fe_range_d, fe_drive_q, fe_drive_d;
	logic [1:0]  fe_wait_q, fe_wait_d;
	logic [18:0] fe_cnt_q, fe_cnt_d, fe_target;
	logic [6:0]  fi_cnt_q, fi_cnt_d;
	logic        fe_st_q, fe_st_d, fi_st_q, fi_st_d;
	logic        si_st_q, si_st_d, se_st_q, se_st_d;
	logic [3:0]  st_vec, src_tick;
	logic        root_tick_q, root_tick_d, halt_q, halt_d;
	logic        root_ok, want_ok;
	power_mode_t pm_q, pm_d;
	logic [AXI_AW-1:0] aw_q, aw_d;
	logic [AXI_DW-1:0] wd_q, wd_d, rdata_q, rdata_d;
	logic        wst_q, wst_d, awh_q, awh_d, wh_q, wh_d;
	logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic        do_write;

	// RULE20 48 MHz RC input
	osc_edge_sync #(.N(OSC_NUM)) u_sync (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.fast_pin_a   (fast_pin_a),
		.rise_out (rise)
	);

	// RULE1 fast internal divide
	tick_divider #(.W(5)) u_fi_div (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.tick_in   (rise[OSC_FI]),
		.factor_in ((fi_div_q == 4'h0) ? 5'h01 : {fi_div_q, 1'b0}),
		.tick_out  (fi_tick)
	);

	// RULE3 core bus divide
	tick_divider #(.W(8)) u_core_div (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.tick_in   (root_tick_q),
		.factor_in (8'h01 << core_pre_q),
		.tick_out  (core_tick)
	);

	// RULE4 peripheral bus divide
	tick_divider #(.W(4)) u_per_div (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.tick_in   (core_tick),
		.factor_in (4'h1 << per_pre_q),
		.tick_out  (periph_bus_tick_out)
	);

	assign src_tick = {rise[OSC_SE], rise[OSC_SI], rise[OSC_FE], fi_tick};
	assign st_vec   = {se_st_q, si_st_q, fe_st_q, fi_st_q};
	assign root_ok  = st_vec[act_q];
	assign want_ok  = st_vec[src_sel_q];

	always_comb begin
		unique case (fe_wait_q)
			2'h0: fe_target = 19'(FE_COUNT0);
			2'h1: fe_target = 19'(FE_COUNT1);
			2'h2: fe_target = 19'(FE_COUNT2);
			2'h3: fe_target = 19'(FE_COUNT3);
		endcase
	end

	// Power mode, source switch, stability
	always_comb begin
		pm_d      = pm_q;
		act_d     = act_q;
		fe_cnt_d  = fe_cnt_q;
		fi_cnt_d  = fi_cnt_q;
		unique case (pm_q)
			PM_ACTIVE: if (sleep_req_in) pm_d = deep_sleep_in ? PM_DEEP : PM_SLEEP;
			PM_SLEEP:  if (wake_req_in) pm_d = PM_ACTIVE;
			PM_DEEP:   if (wake_req_in) pm_d = PM_WAKE;
			// RULE10 hold until source stable
			PM_WAKE:   if (act_q == src_sel_q && root_ok) pm_d = PM_ACTIVE;
		endcase
		// RULE5 sleep keeps oscillators
		en_d = osc_on_q;
		// RULE6 fast oscillators off
		if (pm_d == PM_DEEP) begin
			en_d[OSC_FI] = 1'b0;
			en_d[OSC_FE] = 1'b0;
		end
		// RULE7 slow oscillators untouched
		en_d[EN_NUM-1:OSC_SI] = osc_on_q[EN_NUM-1:OSC_SI];
		halt_d = (pm_d != PM_ACTIVE);
		// RULE21 count external cycles
		if (!en_q[OSC_FE]) fe_cnt_d = '0;
		else if (rise[OSC_FE] && !fe_st_q) fe_cnt_d = fe_cnt_q + 19'h1;
		fe_st_d = en_q[OSC_FE] && (fe_st_q || fe_cnt_q >= fe_target);
		if (!en_q[OSC_FI]) fi_cnt_d = '0;
		else if (rise[OSC_FI] && !fi_st_q) fi_cnt_d = fi_cnt_q + 7'h1;
		fi_st_d = en_q[OSC_FI] && (fi_st_q || fi_cnt_q >= 7'(FI_WAIT));
		si_st_d = en_q[OSC_SI] && (si_st_q || rise[OSC_SI]);
		se_st_d = en_q[OSC_SE] && (se_st_q || rise[OSC_SE]);
		// RULE23 switch only to a stable source
		// RULE22 switch on an old-source tick
		if (src_sel_q != act_q && want_ok && (src_tick[act_q] || !root_ok))
			act_d = src_sel_q;
		// RULE2 RULE8 root tick from running selected source
		root_tick_d = src_tick[act_q] && root_ok;
	end

	// Register bus
	always_comb begin
		aw_d = aw_q;
		wd_d = wd_q;
		wst_d = wst_q;
		awh_d = awh_q;
		wh_d = wh_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		src_sel_d = src_sel_q;
		core_pre_d = core_pre_q;
		per_pre_d = per_pre_q;
		osc_on_d = osc_on_q;
		wake_sel_d = wake_sel_q;
		fi_div_d = fi_div_q;
		fe_mode_d = fe_mode_q;
		fe_range_d = fe_range_q;
		fe_drive_d = fe_drive_q;
		fe_wait_d = fe_wait_q;
		if (axi_awvalid_in && axi_awready_out) begin
			aw_d = axi_awaddr_in;
			awh_d = 1'b1;
		end
		if (axi_wvalid_in && axi_wready_out) begin
			wd_d = axi_wdata_in;
			wst_d = axi_wstrb_in[0];
			wh_d = 1'b1;
		end
		do_write = awh_q && wh_q && !bvalid_q;
		if (do_write) begin
			awh_d = 1'b0;
			wh_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			unique case (aw_q)
				OFS_SYSTEM_CTRL_ZERO: if (wst_q) begin
					src_sel_d = wd_q[F_SRC_LO +: 2];
					core_pre_d = wd_q[F_CORE_LO +: 3];
					per_pre_d = wd_q[F_PER_LO +: 2];
				end
				OFS_OSC_ENABLE: if (wst_q) osc_on_d = wd_q[EN_NUM-1:0];
				OFS_SYSTEM_CTRL_TWO: if (wst_q) wake_sel_d = wd_q[F_WAKE];
				OFS_FAST_INT_CTRL:
					if (wst_q && wd_q[3:0] <= FI_DIV_MAX) fi_div_d = wd_q[3:0];
				// RULE12 RULE15 settings frozen while running
				OFS_FAST_EXT_CTRL: if (wst_q && !osc_on_q[OSC_FE]) begin
					fe_mode_d = wd_q[F_FE_MODE];
					fe_range_d = wd_q[F_FE_RANGE +: 2];
					fe_drive_d = wd_q[F_FE_DRIVE +: 2];
					fe_wait_d = wd_q[F_FE_WAIT +: 2];
				end
				OFS_STATUS: ;
				default: bresp_d = RESP_SLVERR;
			endcase
		end
		if (bvalid_q && axi_bready_in) bvalid_d = 1'b0;
		// RULE9 force fast internal source on wake
		if (pm_q == PM_DEEP && wake_req_in && wake_sel_q) src_sel_d = SRC_FI;
		if (axi_arvalid_in && axi_arready_out) begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			rdata_d = '0;
			unique case (axi_araddr_in)
				OFS_SYSTEM_CTRL_ZERO: begin
					rdata_d[F_SRC_LO +: 2] = src_sel_q;
					rdata_d[F_CORE_LO +: 3] = core_pre_q;
					rdata_d[F_PER_LO +: 2] = per_pre_q;
				end
				OFS_OSC_ENABLE: rdata_d[EN_NUM-1:0] = osc_on_q;
				OFS_SYSTEM_CTRL_TWO: rdata_d[F_WAKE] = wake_sel_q;
				OFS_FAST_INT_CTRL: begin
					rdata_d[3:0] = fi_div_q;
					rdata_d[F_FI_STBL] = fi_st_q;
				end
				OFS_FAST_EXT_CTRL: begin
					rdata_d[F_FE_MODE] = fe_mode_q;
					rdata_d[F_FE_RANGE +: 2] = fe_range_q;
					rdata_d[F_FE_DRIVE +: 2] = fe_drive_q;
					rdata_d[F_FE_WAIT +: 2] = fe_wait_q;
					rdata_d[F_FE_STBL] = fe_st_q;
				end
				OFS_STATUS: begin
					rdata_d[F_SRC_LO +: 2] = act_q;
					rdata_d[F_ST_MODE +: 2] = pm_q;
					rdata_d[F_ST_HALT] = halt_q;
				end
				default: rresp_d = RESP_SLVERR;
			endcase
		end else if (rvalid_q && axi_rready_in) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			pm_q <= PM_ACTIVE;
			act_q <= SRC_FI;
			en_q <= OSC_ON_RST;
			halt_q <= 1'b0;
			fe_cnt_q <= '0;
			fi_cnt_q <= '0;
			fe_st_q <= 1'b0;
			fi_st_q <= 1'b0;
			si_st_q <= 1'b0;
			se_st_q <= 1'b0;
			root_tick_q <= 1'b0;
			aw_q <= '0;
			wd_q <= '0;
			wst_q <= 1'b0;
			awh_q <= 1'b0;
			wh_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= '0;
			src_sel_q <= SRC_FI;
			core_pre_q <= '0;
			per_pre_q <= '0;
			osc_on_q <= OSC_ON_RST;
			wake_sel_q <= 1'b0;
			// RULE19 divide by six at reset
			fi_div_q <= FI_DIV_RST;
			fe_mode_q <= 1'b0;
			fe_range_q <= '0;
			fe_drive_q <= '0;
			fe_wait_q <= FE_WAIT_RST;
		end else begin
			pm_q <= pm_d;
			act_q <= act_d;
			en_q <= en_d;
			halt_q <= halt_d;
			fe_cnt_q <= fe_cnt_d;
			fi_cnt_q <= fi_cnt_d;
			fe_st_q <= fe_st_d;
			fi_st_q <= fi_st_d;
			si_st_q <= si_st_d;
			se_st_q <= se_st_d;
			root_tick_q <= root_tick_d;
			aw_q <= aw_d;
			wd_q <= wd_d;
			wst_q <= wst_d;
			awh_q <= awh_d;
			wh_q <= wh_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			src_sel_q <= src_sel_d;
			core_pre_q <= core_pre_d;
			per_pre_q <= per_pre_d;
			osc_on_q <= osc_on_d;
			wake_sel_q <= wake_sel_d;
			fi_div_q <= fi_div_d;
			fe_mode_q <= fe_mode_d;
			fe_range_q <= fe_range_d;
			fe_drive_q <= fe_drive_d;
			fe_wait_q <= fe_wait_d;
		end
	end

	assign axi_awready_out = !awh_q;
	assign axi_wready_out = !wh_q;
	assign axi_bvalid_out = bvalid_q;
	assign axi_bresp_out = bresp_q;
	assign axi_arready_out = !rvalid_q;
	assign axi_rvalid_out = rvalid_q;
	assign axi_rresp_out = rresp_q;
	assign axi_rdata_out = rdata_q;
	assign cpu_halt_out = halt_q;
	assign root_tick_out = root_tick_q;
	assign core_bus_tick_out = core_tick;
	assign osc_enable_out = en_q;
	// RULE12 RULE13 pin roles follow mode
	assign fast_pin_a_digital_out = fe_mode_q;
	assign fast_pin_b_gpio_out = fe_mode_q;
	assign crystal_range_out = fe_range_q;
	// RULE15 drive level to oscillator
	assign drive_strength_out = fe_drive_q;
	// RULE16 RULE17 RULE18 dedicated clocks
	assign rc_10khz_tick_out = rise[OSC_R10K];
	assign rc_150khz_tick_out = rise[OSC_R150K];
	assign radio_tick_out = rise[OSC_RADIO];

	a_sleep_keeps_osc: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
		pm_q == PM_SLEEP |-> en_q == $past(osc_on_q) && halt_q)
		else $error("sleep changed an oscillator enable");
	a_deep_fast_off: assert property (@(posedge clk_in) disable iff (rst_in) // RULE6
		pm_q == PM_DEEP |-> !en_q[OSC_FI] && !en_q[OSC_FE] && halt_q)
		else $error("fast oscillator on in deep sleep");
	a_deep_slow_kept: assert property (@(posedge clk_in) disable iff (rst_in) // RULE7
		pm_q == PM_DEEP |->
			en_q[EN_NUM-1:OSC_SI] == $past(osc_on_q[EN_NUM-1:OSC_SI]))
		else $error("slow oscillator changed in deep sleep");
	a_root_needs_run: assert property (@(posedge clk_in) disable iff (rst_in) // RULE8
		root_tick_q |-> $past(root_ok))
		else $error("root tick from a source that is not running");
	a_root_from_src: assert property (@(posedge clk_in) disable iff (rst_in) // RULE2
		root_tick_q |-> $past(src_tick[act_q]))
		else $error("root tick without a tick of the active source");
	a_switch_stable: assert property (@(posedge clk_in) disable iff (rst_in) // RULE23
		$changed(act_q) |-> $past(want_ok) && act_q == $past(src_sel_q))
		else $error("switched to an unstable source");
	a_wake_forces_fi: assert property (@(posedge clk_in) disable iff (rst_in) // RULE9
		pm_q == PM_DEEP && wake_req_in && wake_sel_q |=> src_sel_q == SRC_FI)
		else $error("wake did not select fast internal clock");
	a_wake_holds_cpu: assert property (@(posedge clk_in) disable iff (rst_in) // RULE10
		pm_q == PM_WAKE && !(act_q == src_sel_q && root_ok) |=> halt_q)
		else $error("processor released before source stable");
	a_fe_stable_count: assert property (@(posedge clk_in) disable iff (rst_in) // RULE21
		$rose(fe_st_q) |-> $past(fe_cnt_q) >= $past(fe_target))
		else $error("external stable flag set too early");

endmodule

// ===== clock_tree_pkg.sv
// Shared constants and types of the system clock tree control block
package clock_tree_pkg;

	localparam int AXI_AW = 8;
	localparam int AXI_DW = 32;

	// Register byte offsets
	localparam logic [AXI_AW-1:0] OFS_SYSTEM_CTRL_ZERO = 8'h00;
	localparam logic [AXI_AW-1:0] OFS_OSC_ENABLE       = 8'h04;
	localparam logic [AXI_AW-1:0] OFS_SYSTEM_CTRL_TWO  = 8'h08;
	localparam logic [AXI_AW-1:0] OFS_FAST_INT_CTRL    = 8'h0c;
	localparam logic [AXI_AW-1:0] OFS_FAST_EXT_CTRL    = 8'h10;
	localparam logic [AXI_AW-1:0] OFS_STATUS           = 8'h14;

	// Field positions
	localparam int F_SRC_LO   = 0;
	localparam int F_CORE_LO  = 2;
	localparam int F_PER_LO   = 5;
	localparam int F_WAKE     = 0;
	localparam int F_FI_STBL  = 4;
	localparam int F_FE_MODE  = 0;
	localparam int F_FE_RANGE = 1;
	localparam int F_FE_DRIVE = 3;
	localparam int F_FE_WAIT  = 5;
	localparam int F_FE_STBL  = 7;
	localparam int F_ST_MODE  = 2;
	localparam int F_ST_HALT  = 4;

	// Root source codes
	localparam logic [1:0] SRC_FI = 2'h0;
	localparam logic [1:0] SRC_FE = 2'h1;
	localparam logic [1:0] SRC_SI = 2'h2;
	localparam logic [1:0] SRC_SE = 2'h3;

	// Oscillator input and enable indices
	localparam int OSC_FI    = 0;
	localparam int OSC_FE    = 1;
	localparam int OSC_SI    = 2;
	localparam int OSC_SE    = 3;
	localparam int OSC_R10K  = 4;
	localparam int OSC_R150K = 5;
	localparam int OSC_RADIO = 6;
	localparam int OSC_NUM   = 7;
	localparam int EN_NUM    = 6;

	// Reset values
	localparam logic [EN_NUM-1:0] OSC_ON_RST = 6'h31;
	localparam logic [3:0] FI_DIV_RST  = 4'h3;
	localparam logic [3:0] FI_DIV_MAX  = 4'h8;
	localparam logic [1:0] FE_WAIT_RST = 2'h2;

	// Stability counts in oscillator cycles
	localparam int FE_WAIT0 = 8192;
	localparam int FE_WAIT1 = 32768;
	localparam int FE_WAIT2 = 131072;
	localparam int FE_WAIT3 = 262144;
	localparam int FI_WAIT  = 64;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		PM_ACTIVE,
		PM_SLEEP,
		PM_DEEP,
		PM_WAKE
	} power_mode_t;

endpackage

// ===== osc_edge_sync.sv
// Synchroniser and rising-edge tick for each oscillator input
`timescale 1ns/1ns
module osc_edge_sync #(
	parameter int N = 7
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [N-1:0] fast_pin_a,
	output logic      [N-1:0] rise_out
);
	logic [N-1:0] meta_q;
	logic [N-1:0] sync_q;
	logic [N-1:0] last_q;
	logic [N-1:0] rise_d;
	logic [N-1:0] rise_q;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			always_comb begin
				rise_d[i] = sync_q[i] & ~last_q[i];
			end
			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					meta_q[i] <= 1'b0;
					sync_q[i] <= 1'b0;
					last_q[i] <= 1'b0;
					rise_q[i] <= 1'b0;
				end else begin
					meta_q[i] <= fast_pin_a[i];
					sync_q[i] <= meta_q[i];
					last_q[i] <= sync_q[i];
					rise_q[i] <= rise_d[i];
				end
			end
		end
	endgenerate

	assign rise_out = rise_q;
endmodule

// ===== tick_divider.sv
// Programmable divider of a tick stream, new factor taken at wrap only
`timescale 1ns/1ns
module tick_divider #(
	parameter int W = 8
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic         tick_in,
	input  wire logic [W-1:0] factor_in,
	output logic              tick_out
);
	logic [W-1:0] count_q;
	logic [W-1:0] count_d;
	logic [W-1:0] factor_q;
	logic [W-1:0] factor_d;
	logic         tick_q;
	logic         tick_d;
	logic [W:0]   next_cnt;

	always_comb begin
		count_d  = count_q;
		factor_d = factor_q;
		tick_d   = 1'b0;
		next_cnt = {1'b0, count_q} + {{W{1'b0}}, 1'b1};
		if (tick_in) begin
			if (next_cnt >= {1'b0, factor_q}) begin
				count_d  = '0;
				tick_d   = 1'b1;
				factor_d = factor_in;
			end else begin
				count_d = next_cnt[W-1:0];
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count_q  <= '0;
			factor_q <= '0;
			tick_q   <= 1'b0;
		end else begin
			count_q  <= count_d;
			factor_q <= factor_d;
			tick_q   <= tick_d;
		end
	end

	assign tick_out = tick_q;
endmodule

// ===== testbench.sv
// Self-checking testbench of the system clock tree control block
`timescale 1ns/1ns
module testbench;
	import clock_tree_pkg::*;
	typedef struct {logic [31:0] v; logic [31:0] m; logic [1:0] r;} exp_t;
	logic        clk_in, rst_in, awvalid, wvalid, bready, arvalid, rready;
	logic        sleep_req, deep_sleep, wake_req;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata;
	logic [6:0]  osc = '0, osc_q = '0;
	wire         awready, wready, bvalid, arready, rvalid, halt, pin_a, pin_b;
	wire  [1:0]  bresp, rresp, range, drive;
	wire  [31:0] rdata;
	wire  [5:0]  osc_en, tk;
	exp_t        exp_q[$];
	int          err_count, cmp_count;
	int          hp[7] = '{2, 3, 5, 7, 9, 6, 4};
	int          codes[4] = '{0, 1, 3, 8};
	int          hc[7], e_cnt[7], t_cnt[6], de[7], dt[6];

	system_clock_tree_control #(.FE_COUNT0(8), .FE_COUNT1(16),
		.FE_COUNT2(32), .FE_COUNT3(64)) u_system_clock_tree_control (
		.clk_in(clk_in), .rst_in(rst_in), .axi_awaddr_in(awaddr),
		.axi_awvalid_in(awvalid), .axi_awready_out(awready),
		.axi_wdata_in(wdata), .axi_wstrb_in(4'hf), .axi_wvalid_in(wvalid),
		.axi_wready_out(wready), .axi_bresp_out(bresp),
		.axi_bvalid_out(bvalid), .axi_bready_in(bready),
		.axi_araddr_in(araddr), .axi_arvalid_in(arvalid),
		.axi_arready_out(arready), .axi_rdata_out(rdata),
		.axi_rresp_out(rresp), .axi_rvalid_out(rvalid),
		.axi_rready_in(rready), .sleep_req_in(sleep_req),
		.deep_sleep_in(deep_sleep), .wake_req_in(wake_req), .fast_pin_a(osc),
		.cpu_halt_out(halt), .root_tick_out(tk[0]),
		.core_bus_tick_out(tk[1]), .periph_bus_tick_out(tk[2]),
		.osc_enable_out(osc_en), .fast_pin_a_digital_out(pin_a),
		.fast_pin_b_gpio_out(pin_b), .crystal_range_out(range),
		.drive_strength_out(drive), .rc_10khz_tick_out(tk[3]),
		.rc_150khz_tick_out(tk[4]), .radio_tick_out(tk[5]));

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	// Oscillators toggle only while enabled, the radio one always
	always @(posedge clk_in) begin
		for (int i = 0; i < 7; i++) begin
			hc[i] = hc[i] + 1;
			if (hc[i] >= hp[i] && (i == 6 || osc_en[i] === 1'b1)) begin
				hc[i] = 0;
				osc[i] <= ~osc[i];
			end
		end
	end

	always @(negedge clk_in) begin
		for (int i = 0; i < 7; i++)
			if (osc[i] && !osc_q[i]) e_cnt[i]++;
		for (int i = 0; i < 6; i++)
			if (tk[i] === 1'b1) t_cnt[i]++;
		osc_q = osc;
	end

	always @(posedge clk_in) begin
		if (rvalid === 1'b1 && rready === 1'b1) begin
			if (exp_q.size() == 0)
				fail("read without a note");
			else
				cmp_rd(exp_q.pop_front());
		end
	end

	task automatic fail(input string s);
		err_count++;
		$display("[ERR] %0t %s", $time, s);
	endtask

	task automatic chk_v(input logic [7:0] g, input logic [7:0] e,
		input string s);
		cmp_count++;
		if (g !== e) fail(s);
	endtask

	task automatic chk_near(input int g, input int e, input string s);
		cmp_count++;
		if (g > e + 2 || g < e - 2) fail(s);
	endtask

	task automatic cmp_rd(input exp_t e);
		cmp_count++;
		if (!((rdata & e.m) === e.v && rresp === e.r)) fail("read data");
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		bit aw_ok, w_ok;
		aw_ok = 0;
		w_ok = 0;
		@(posedge clk_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk_in);
			if (awvalid && awready === 1'b1) begin
				aw_ok = 1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1) begin
				w_ok = 1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge clk_in);
		chk_v(bresp, er, "write response");
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] v,
		input logic [31:0] m, input logic [1:0] er);
		exp_q.push_back(exp_t'{v, m, er});
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_in); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_in); while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask

	task automatic measure(input int n);
		int s0[7], s1[6];
		s0 = e_cnt;
		s1 = t_cnt;
		repeat (n) @(posedge clk_in);
		foreach (de[i]) de[i] = e_cnt[i] - s0[i];
		foreach (dt[i]) dt[i] = t_cnt[i] - s1[i];
	endtask

	task automatic power_cycle(input logic dp, input logic [1:0] src,
		input bit runs);
		logic [5:0] en0;
		int n;
		@(posedge clk_in);
		en0 = osc_en;
		sleep_req <= 1'b1;
		deep_sleep <= dp;
		@(posedge clk_in);
		sleep_req <= 1'b0;
		@(posedge clk_in);
		chk_v(halt, 1'b1, "halt on entry");
		chk_v(osc_en[1:0], dp ? 2'b00 : en0[1:0], "fast osc");
		chk_v(osc_en[5:2], en0[5:2], "slow osc");
		repeat (4) @(posedge clk_in);
		measure(200);
		chk_v(dt[0] > 0, runs, "root clock while halted");
		wake_req <= 1'b1;
		@(posedge clk_in);
		wake_req <= 1'b0;
		n = 0;
		while (halt !== 1'b0 && n < 1000) begin
			@(posedge clk_in);
			n++;
		end
		chk_v(halt, 1'b0, "halt after wake");
		rd(OFS_STATUS, {30'h0, src}, 32'h1f, RESP_OKAY);
		$display("test power mode %0d done", dp);
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#(240000);
		fail("watchdog expired");
		close_out();
	end

	initial begin
		logic [1:0]  rng;
		logic [31:0] fe;
		int          n, m, f;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{sleep_req, deep_sleep, wake_req} = 3'h0;
		{awaddr, araddr, wdata} = '0;
		void'($urandom(32'h167ea969));
		rst_in = 1'b1;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(OFS_SYSTEM_CTRL_ZERO, 32'h0, 32'h7f, RESP_OKAY);
		rd(OFS_OSC_ENABLE, 32'h31, 32'h3f, RESP_OKAY);
		rd(OFS_FAST_INT_CTRL, 32'h3, 32'hf, RESP_OKAY);
		rd(OFS_FAST_EXT_CTRL, 32'h40, 32'hff, RESP_OKAY);
		rd(8'h18, 32'h0, 32'hffffffff, RESP_SLVERR);
		wr(8'h1c, 32'h0, RESP_SLVERR);
		wr(OFS_FAST_INT_CTRL, 32'h9, RESP_OKAY);
		rd(OFS_FAST_INT_CTRL, 32'h3, 32'hf, RESP_OKAY);
		$display("test reset values done");
		for (int d = 0; d < 4; d++) begin
			rng = 2'($urandom_range(3));
			fe = 32'h60 | 32'(d << 3) | (32'(rng) << 1) | 32'(d & 1);
			wr(OFS_FAST_EXT_CTRL, fe, RESP_OKAY);
			repeat (2) @(posedge clk_in);
			chk_v(pin_a, fe[0], "pin a mode");
			chk_v(pin_b, fe[0], "pin b released");
			chk_v(range, rng, "crystal range");
			chk_v(drive, fe[4:3], "drive level");
		end
		wr(OFS_OSC_ENABLE, 32'h3f, RESP_OKAY);
		rd(OFS_FAST_EXT_CTRL, fe, 32'hff, RESP_OKAY);
		wr(OFS_FAST_EXT_CTRL, 32'h0, RESP_OKAY);
		repeat (500) @(posedge clk_in);
		rd(OFS_FAST_EXT_CTRL, fe | 32'h80, 32'hff, RESP_OKAY);
		$display("test external oscillator done");
		for (int s = 0; s < 4; s++) begin
			wr(OFS_SYSTEM_CTRL_ZERO, 32'(s), RESP_OKAY);
			repeat (100) @(posedge clk_in);
			rd(OFS_STATUS, 32'(s), 32'h3, RESP_OKAY);
			measure(2048);
			chk_near(dt[0], de[s] / (s == 0 ? 6 : 1), "root");
			chk_near(dt[3], de[4], "10 kHz route");
			chk_near(dt[4], de[5], "150 kHz route");
			chk_near(dt[5], de[6], "radio route");
		end
		wr(OFS_OSC_ENABLE, 32'h3d, RESP_OKAY);
		wr(OFS_SYSTEM_CTRL_ZERO, 32'h1, RESP_OKAY);
		repeat (100) @(posedge clk_in);
		rd(OFS_STATUS, 32'h3, 32'h3, RESP_OKAY);
		$display("test source select done");
		wr(OFS_SYSTEM_CTRL_ZERO, 32'h2, RESP_OKAY);
		repeat (100) @(posedge clk_in);
		power_cycle(1'b0, SRC_SI, 1'b1);
		power_cycle(1'b1, SRC_SI, 1'b1);
		wr(OFS_SYSTEM_CTRL_TWO, 32'h1, RESP_OKAY);
		power_cycle(1'b1, SRC_FI, 1'b1);
		rd(OFS_SYSTEM_CTRL_ZERO, 32'h0, 32'h3, RESP_OKAY);
		power_cycle(1'b1, SRC_FI, 1'b0);
		for (int k = 0; k < 4; k++) begin
			n = (k == 3) ? 7 : int'($urandom_range(3));
			m = (k == 3) ? 3 : int'($urandom_range(3));
			wr(OFS_FAST_INT_CTRL, 32'(codes[k]), RESP_OKAY);
			wr(OFS_SYSTEM_CTRL_ZERO, 32'((m << 5) | (n << 2)), RESP_OKAY);
			repeat (2000) @(posedge clk_in);
			measure(2048);
			f = (codes[k] == 0) ? 1 : 2 * codes[k];
			chk_near(dt[0], de[0] / f, "fast internal divide");
			chk_near(dt[1], dt[0] >> n, "core divide");
			chk_near(dt[2], dt[1] >> m, "peripheral divide");
		end
		$display("test dividers done");
		repeat (4) @(posedge clk_in);
		close_out();
	end
endmodule
